// [pkg/lfbcs_pkg.sv]
// constants and state types for the lcd frame and boost clock select block
package lfbcs_pkg;

    // register byte addresses
    localparam logic [7:0] LFBCS_CTRL_ADDR   = 8'h28;
    localparam logic [7:0] LFBCS_MODE_ADDR   = 8'h2C;
    localparam logic [7:0] LFBCS_STATUS_ADDR = 8'h30;

    // control register fields
    localparam int         LFBCS_DISP_BIT    = 7;
    localparam int         LFBCS_BOOST_BIT   = 6;
    localparam int         LFBCS_VFS_LSB     = 4;
    localparam int         LFBCS_DUTY_LSB    = 2;
    localparam int         LFBCS_SLF_LSB     = 0;
    localparam logic [7:0] LFBCS_CTRL_RESET  = 8'h00;

    // mode register fields
    localparam int         LFBCS_DUAL_BIT    = 0;
    localparam int         LFBCS_DVSRC_BIT   = 1;
    localparam int         LFBCS_SYSSRC_BIT  = 2;
    localparam logic [2:0] LFBCS_MODE_RESET  = 3'h0;

    // status register fields
    localparam int         LFBCS_ST_PHASE_LSB = 0;
    localparam int         LFBCS_ST_LF_BIT    = 2;
    localparam int         LFBCS_ST_BCLK_BIT  = 3;

    // drive method codes
    localparam logic [1:0] LFBCS_DUTY_QUARTER = 2'h0;
    localparam logic [1:0] LFBCS_DUTY_THIRD   = 2'h1;
    localparam logic [1:0] LFBCS_DUTY_HALF    = 2'h2;
    localparam logic [1:0] LFBCS_DUTY_STATIC  = 2'h3;

    // divider exponents
    localparam logic [4:0] LFBCS_HF_SLF0 = 5'h11;
    localparam logic [4:0] LFBCS_HF_SLF1 = 5'h10;
    localparam logic [4:0] LFBCS_HF_SLF2 = 5'h0F;
    localparam logic [4:0] LFBCS_HF_SLF3 = 5'h0D;
    localparam logic [4:0] LFBCS_LF_SLF0 = 5'h09;
    localparam logic [4:0] LFBCS_LF_SLF1 = 5'h08;
    localparam logic [4:0] LFBCS_HF_VF0  = 5'h0D;
    localparam logic [4:0] LFBCS_HF_VF1  = 5'h0B;
    localparam logic [4:0] LFBCS_HF_VF2  = 5'h0A;
    localparam logic [4:0] LFBCS_HF_VF3  = 5'h09;
    localparam logic [4:0] LFBCS_LF_VF0  = 5'h05;
    localparam logic [4:0] LFBCS_LF_VF1  = 5'h03;
    localparam logic [4:0] LFBCS_LF_VF2  = 5'h02;
    localparam logic [4:0] LFBCS_PHASE_SHIFT = 5'h02;

    localparam int LFBCS_HF_WIDTH = 17;
    localparam int LFBCS_LF_WIDTH = 9;

    // whole state of the select block
    typedef struct packed {
        logic [7:0] ctrl;
        logic [2:0] mode;
        logic       ack;
        logic [7:0] rdata;
        logic [1:0] phase;
        logic       phaseTick;
        logic       frameTick;
        logic       boostTick;
        logic       boostClk;
    } lfbcs_state_t;

endpackage : lfbcs_pkg

// [hdl/lfbcs_divider.sv]
// free-running ripple-free divider counter advanced by an oscillator tick
`timescale 1ns/10ps
module lfbcs_divider
    import lfbcs_pkg::*;
#(
    parameter int WIDTH = 17
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             tick,
    output logic      [WIDTH-1:0] count
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } lfbcs_div_state_t;

    lfbcs_div_state_t state_reg;
    lfbcs_div_state_t state_next;

    // counts oscillator ticks only, never stops so taps stay phase aligned
    always_comb begin
        state_next = state_reg;
        if (tick) begin
            state_next.count = state_reg.count + WIDTH'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign count = state_reg.count;

endmodule : lfbcs_divider

// [hdl/lfbcs_clock_select.sv]
// lcd frame, common phase and boost clock selection with wishbone registers
`timescale 1ns/10ps
module lfbcs_clock_select
    import lfbcs_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic          mclk,
    input  wire logic          rst_b,
    input  wire logic          hfTick,
    input  wire logic          lfTick,
    input  wire logic          cyc_i,
    input  wire logic          stb_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] adr_i,
    input  wire logic [3:0]    sel_i,
    input  wire logic [31:0]   dat_i,
    output logic      [31:0]   dat_o,
    output logic               ack_o,
    output logic               displayEnable,
    output logic               boostEnable,
    output logic [1:0]         dutyMode,
    output logic [1:0]         comPhase,
    output logic               phaseTick,
    output logic               frameTick,
    output logic               boostTick,
    output logic               boostClk,
    output logic               lfSourceActive
);

    // whole block state, one bank so reset and update stay in one place
    lfbcs_state_t state_reg;
    lfbcs_state_t state_next;

    // raw divider counts; the slow one is narrow since its taps stop at 2^9
    logic [LFBCS_HF_WIDTH-1:0] hfCount;
    logic [LFBCS_LF_WIDTH-1:0] lfCount;

    // true on the tick that rolls the low e bits over, i.e. a divide by 2^e
    // one mask compare per tap lets every ratio of one oscillator share its counter
    function automatic logic tapHit(input logic [LFBCS_HF_WIDTH-1:0] cnt,
                                    input logic [4:0]                e);
        logic [LFBCS_HF_WIDTH-1:0] m;
        m = LFBCS_HF_WIDTH'((32'h1 << e) - 32'h1);
        return (cnt & m) == m;
    endfunction : tapHit

    // index of the last common phase in a frame for a drive code
    // static has a single phase, so every step closes a frame
    function automatic logic [1:0] lastPhase(input logic [1:0] duty);
        case (duty)
            LFBCS_DUTY_QUARTER: lastPhase = 2'h3;
            LFBCS_DUTY_THIRD:   lastPhase = 2'h2;
            LFBCS_DUTY_HALF:    lastPhase = 2'h1;
            default:            lastPhase = 2'h0;
        endcase
    endfunction : lastPhase

    // fast oscillator divider, wide enough for the slowest frame base
    // counters never restart on a register write, so a new tap may cut one period
    lfbcs_divider #(
        .WIDTH (LFBCS_HF_WIDTH)
    ) u_hfDiv (
        .mclk  (mclk),
        .rst_b (rst_b),
        .tick  (hfTick),
        .count (hfCount)
    );

    // slow oscillator divider for the low-frequency taps
    lfbcs_divider #(
        .WIDTH (LFBCS_LF_WIDTH)
    ) u_lfDiv (
        .mclk  (mclk),
        .rst_b (rst_b),
        .tick  (lfTick),
        .count (lfCount)
    );

    // decoded fields and the selected tap of each clock
    logic                      lfMode;
    logic [1:0]                slfCode;
    logic [1:0]                vfsCode;
    logic [1:0]                dutyCode;
    logic                      frameLf;
    logic                      boostLf;
    logic [4:0]                baseExp;
    logic [4:0]                phaseExp;
    logic [4:0]                boostExp;
    logic [LFBCS_HF_WIDTH-1:0] frameCnt;
    logic [LFBCS_HF_WIDTH-1:0] boostCnt;
    logic                      frameSrcTick;
    logic                      boostSrcTick;
    logic                      phaseHit;
    logic                      boostHit;

    // source and exponent selection from the control and mode fields
    always_comb begin
        slfCode  = state_reg.ctrl[LFBCS_SLF_LSB +: 2];
        vfsCode  = state_reg.ctrl[LFBCS_VFS_LSB +: 2];
        dutyCode = state_reg.ctrl[LFBCS_DUTY_LSB +: 2];
        // low-frequency taps when dual with stage source set, or slow system clock
        lfMode   = (state_reg.mode[LFBCS_DUAL_BIT] & state_reg.mode[LFBCS_DVSRC_BIT])
                 | state_reg.mode[LFBCS_SYSSRC_BIT];
        // base codes 10/11 have no slow tap, they stay on the fast divider
        frameLf  = lfMode & ~slfCode[1];
        boostLf  = lfMode & (vfsCode != 2'h3);
        case (slfCode)
            2'h0:    baseExp = frameLf ? LFBCS_LF_SLF0 : LFBCS_HF_SLF0;
            2'h1:    baseExp = frameLf ? LFBCS_LF_SLF1 : LFBCS_HF_SLF1;
            2'h2:    baseExp = LFBCS_HF_SLF2;
            default: baseExp = LFBCS_HF_SLF3;
        endcase
        // boost exponent; code 11 stays on the fast clock in every mode
        case (vfsCode)
            2'h0:    boostExp = boostLf ? LFBCS_LF_VF0 : LFBCS_HF_VF0;
            2'h1:    boostExp = boostLf ? LFBCS_LF_VF1 : LFBCS_HF_VF1;
            2'h2:    boostExp = boostLf ? LFBCS_LF_VF2 : LFBCS_HF_VF2;
            default: boostExp = LFBCS_HF_VF3;
        endcase
        // multiplexed drives step phases at four times base, which yields
        // frame = base, 4/3 base and 2x base for 4, 3 and 2 phases
        // the shift is safe: every multiplexed base exponent is at least 8
        if (dutyCode == LFBCS_DUTY_STATIC) begin
            phaseExp = baseExp;
        end else begin
            phaseExp = baseExp - LFBCS_PHASE_SHIFT;
        end
        // route the chosen counter and its tick to each tap compare
        // the tick qualifies a hit so a stalled oscillator never repeats a pulse
        frameCnt     = frameLf ? LFBCS_HF_WIDTH'(lfCount) : hfCount;
        boostCnt     = boostLf ? LFBCS_HF_WIDTH'(lfCount) : hfCount;
        frameSrcTick = frameLf ? lfTick : hfTick;
        boostSrcTick = boostLf ? lfTick : hfTick;
        phaseHit     = frameSrcTick & tapHit(frameCnt, phaseExp);
        boostHit     = boostSrcTick & tapHit(boostCnt, boostExp);
    end

    // bus decode helpers
    logic       busReq;
    logic       busWrite;
    logic [7:0] wordAddr;
    logic [7:0] readVal;

    // next state: bus slave, phase sequencer and clock pulses
    always_comb begin
        state_next = state_reg;
        wordAddr   = 8'({adr_i[AW-1:2], 2'h0});
        // cyc and stb together form the classic request
        busReq     = cyc_i & stb_i;
        // write lands on the edge where the master sees ack high
        busWrite   = busReq & we_i & state_reg.ack & sel_i[0];
        // read mux; status is captured on the edge the request is taken
        case (wordAddr)
            LFBCS_CTRL_ADDR:   readVal = state_reg.ctrl;
            LFBCS_MODE_ADDR:   readVal = {5'h00, state_reg.mode};
            LFBCS_STATUS_ADDR: readVal = {4'h0, state_reg.boostClk, lfMode,
                                          state_reg.phase};
            default:           readVal = 8'h00;
        endcase
        // one wait state, ack for one cycle, then dropped
        // a request held past ack is taken again only once ack has dropped
        state_next.ack = busReq & ~state_reg.ack;
        if (busReq & ~state_reg.ack) begin
            state_next.rdata = readVal;
        end
        // sel_i[0] gates every write, all registers are one byte wide
        if (busWrite && wordAddr == LFBCS_CTRL_ADDR) begin
            state_next.ctrl = dat_i[7:0];
        end
        // mode bits choose single, dual or slow-system clocking
        if (busWrite && wordAddr == LFBCS_MODE_ADDR) begin
            state_next.mode = dat_i[2:0];
        end
        // phase wraps at the active duty count; >= covers a mid-frame duty change
        // pulses are registered so they line up with comPhase
        state_next.phaseTick = phaseHit;
        state_next.frameTick = 1'b0;
        if (phaseHit) begin
            if (state_reg.phase >= lastPhase(dutyCode)) begin
                state_next.phase     = 2'h0;
                state_next.frameTick = 1'b1;
            end else begin
                state_next.phase = state_reg.phase + 2'h1;
            end
        end
        // booster clock only runs when the internal pump is chosen
        // parking it low keeps ripple off the external divider levels
        state_next.boostTick = boostHit & state_reg.ctrl[LFBCS_BOOST_BIT];
        if (!state_reg.ctrl[LFBCS_BOOST_BIT]) begin
            state_next.boostClk = 1'b0;
        end else if (boostHit) begin
            state_next.boostClk = ~state_reg.boostClk;
        end
    end

    // asynchronous reset parks every field at its reset value
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg       <= '0;
            state_reg.ctrl  <= LFBCS_CTRL_RESET;
            state_reg.mode  <= LFBCS_MODE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs come straight from the state flops
    assign dat_o          = {24'h000000, state_reg.rdata};
    assign ack_o          = state_reg.ack;
    assign displayEnable  = state_reg.ctrl[LFBCS_DISP_BIT];
    assign boostEnable    = state_reg.ctrl[LFBCS_BOOST_BIT];
    assign dutyMode       = state_reg.ctrl[LFBCS_DUTY_LSB +: 2];
    assign comPhase       = state_reg.phase;
    assign phaseTick      = state_reg.phaseTick;
    assign frameTick      = state_reg.frameTick;
    assign boostTick      = state_reg.boostTick;
    assign boostClk       = state_reg.boostClk;
    // source flag decodes the mode flops; a mode write moves it at once
    assign lfSourceActive = lfMode;

endmodule : lfbcs_clock_select

// [verification/lfbcs_clock_select_props.sv]
// concurrent checks on the ports of the lcd clock select block
`timescale 1ns/10ps
module lfbcs_clock_select_props
    import lfbcs_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        boostEnable,
    input wire logic [1:0]  dutyMode,
    input wire logic [1:0]  comPhase,
    input wire logic        phaseTick,
    input wire logic        frameTick,
    input wire logic        boostTick,
    input wire logic        boostClk
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // bus answer timing, one wait state
    AST_ACK_LATENCY: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_IDLE: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    AST_RDATA_HIGH: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_RDATA_HOLD: assert property (!ack_o |-> $stable(dat_o))
        else $error("read data changed without ack");
    // booster clock only runs with the internal booster chosen
    AST_BOOST_OFF: assert property ((!boostEnable && !$past(boostEnable)) |-> (!boostTick && !boostClk))
        else $error("boost clock active while booster off");
    AST_BOOST_TOGGLE: assert property ((boostEnable && $past(boostEnable)) |-> ($changed(boostClk) == boostTick))
        else $error("boost clock toggle not tied to boost tick");
    // common phase sequencing
    AST_FRAME_AT_WRAP: assert property (frameTick |-> (phaseTick && comPhase == 2'h0))
        else $error("frame tick away from phase wrap");
    AST_PHASE_STEP: assert property ((phaseTick && !frameTick) |-> comPhase == $past(comPhase) + 2'h1)
        else $error("phase did not advance by one");
    AST_STATIC_WRAP: assert property ((phaseTick && dutyMode == LFBCS_DUTY_STATIC && $stable(dutyMode) && $past(comPhase) == 2'h0) |-> frameTick)
        else $error("static drive phase step without frame");
    AST_PHASE_GAP: assert property (phaseTick |=> !phaseTick [*8])
        else $error("phase ticks too close");

    COV_HALF_FRAME: cover property (frameTick && dutyMode == LFBCS_DUTY_HALF);
    COV_STATIC_FRAME: cover property (frameTick && dutyMode == LFBCS_DUTY_STATIC);
    COV_BOOST_TICK: cover property (boostTick && boostEnable);
endmodule : lfbcs_clock_select_props

bind lfbcs_clock_select lfbcs_clock_select_props u_props (
    .mclk(mclk), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .boostEnable(boostEnable), .dutyMode(dutyMode), .comPhase(comPhase),
    .phaseTick(phaseTick), .frameTick(frameTick), .boostTick(boostTick), .boostClk(boostClk));

// [verification/lfbcs_cpu_model.sv]
// behavioural cpu that reaches the lcd registers over classic wishbone
`timescale 1ns/10ps
module lfbcs_cpu_model
    import lfbcs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        ack_o,
    input  wire logic [31:0] dat_o,
    output logic             cyc_i,
    output logic             stb_i,
    output logic             we_i,
    output logic [7:0]       adr_i,
    output logic [3:0]       sel_i,
    output logic [31:0]      dat_i
);
    // park the bus before the first request; called by the bench process
    task automatic idle;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        adr_i <= 8'h00;
        sel_i <= 4'h0;
        dat_i <= 32'h00000000;
    endtask : idle

    // one classic cycle; ack and read data are taken at the rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q, output bit ok);
        int n;
        n = 0;
        if (w && a == LFBCS_CTRL_ADDR && d[LFBCS_BOOST_BIT])
            d[LFBCS_DUTY_LSB+1] = 1'b0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q  = dat_o;
        ok = (ack_o === 1'b1);
        // released address and data lines show the inverse so stale values never look valid
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        adr_i <= ~a;
        dat_i <= ~d;
        @(posedge mclk);
    endtask : xfer
endmodule : lfbcs_cpu_model

// [verification/lfbcs_clock_select_tb_top.sv]
// self-checking bench for the lcd frame and boost clock select block
`timescale 1ns/10ps
`define LFBCS_CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
    error_cnt++; $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module lfbcs_clock_select_tb_top
    import lfbcs_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_b, hfTick, cyc, stb, we, ack, dispEn, boostEn;
    logic        phTick, frTick, bTick, bClk, lfSrc;
    logic [7:0]  adr, e, d;
    logic [3:0]  sel, s;
    logic [31:0] wdat, rdat, q;
    logic [1:0]  duty, phase;
    logic [1:0]  lfCnt = 2'h0;
    logic        lfTick = 1'b0;
    logic [2:0]  taps;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          seed = 32'hEB66A2E4;
    int          p, i;

    assign taps = {phTick, frTick, bTick};

    lfbcs_clock_select uut (.mclk(mclk), .rst_b(rst_b), .hfTick(hfTick), .lfTick(lfTick),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .displayEnable(dispEn), .boostEnable(boostEn),
        .dutyMode(duty), .comPhase(phase), .phaseTick(phTick), .frameTick(frTick),
        .boostTick(bTick), .boostClk(bClk), .lfSourceActive(lfSrc));
    lfbcs_cpu_model cpu (.mclk(mclk), .ack_o(ack), .dat_o(rdat), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat));

    initial forever #25 mclk = ~mclk;

    // slow oscillator ticks every fourth cycle so low-frequency periods stay short
    always @(posedge mclk) begin
        lfCnt  <= lfCnt + 2'h1;
        lfTick <= (lfCnt == 2'h3);
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] sl,
                       input logic [7:0] v);
        bit ok;
        @(posedge mclk);
        cpu.xfer(w, a, sl, {24'h000000, v}, q, ok);
        if (!ok) begin error_cnt++; end_sim(); end
    endtask : bus

    // cycles between two pulses on one tap; the first gap after a change may be short
    task automatic period(input int k, output int n);
        repeat (2) begin
            n = 0;
            do begin @(negedge mclk); n++; end while (taps[k] !== 1'b1 && n < 20000);
            if (n >= 20000) begin error_cnt++; end_sim(); end
        end
    endtask : period

    function automatic logic [7:0] legal(input logic [7:0] v);
        return v[6] ? (v & 8'hF7) : v;
    endfunction : legal

    // frame base code 11 on the fast clock, scaled by the active duty
    function automatic int frameLen(input int dm);
        int b;
        b = 1 << LFBCS_HF_SLF3;
        return (dm == 1) ? b * 3 / 4 : (dm == 2) ? b / 2 : b;
    endfunction : frameLen

    function automatic int boostLen(input int c);
        return 1 << ((c == 3) ? LFBCS_HF_VF3 : (c == 2) ? LFBCS_HF_VF2 : LFBCS_HF_VF1);
    endfunction : boostLen

    initial begin
        rst_b  = 1'b0;
        hfTick = 1'b1;
        cpu.idle();
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        bus(1'b0, LFBCS_CTRL_ADDR, 4'hF, 8'h00);
        `LFBCS_CHK("ctrl reset", LFBCS_CTRL_RESET, q[7:0])
        bus(1'b0, LFBCS_MODE_ADDR, 4'hF, 8'h00);
        `LFBCS_CHK("mode reset", LFBCS_MODE_RESET, q[2:0])
        // random control words; a clear lane zero leaves the old value
        e = 8'h00;
        for (i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'hFF : 8'($random(seed));
            s = (i == 0) ? 4'hF : 4'($random(seed));
            bus(1'b1, LFBCS_CTRL_ADDR, s, d);
            if (s[0]) e = legal(d);
            bus(1'b0, LFBCS_CTRL_ADDR, 4'hF, 8'h00);
            `LFBCS_CHK("ctrl", e, q[7:0])
            `LFBCS_CHK("duty pins", e[3:2], duty)
            `LFBCS_CHK("boost pin", e[6], boostEn)
            `LFBCS_CHK("display pin", e[7], dispEn)
        end
        bus(1'b1, 8'h40, 4'hF, 8'hFF);
        bus(1'b0, 8'h40, 4'hF, 8'h00);
        `LFBCS_CHK("unmapped read", 32'h00000000, q)
        $display("registers done");
        for (i = 0; i < 4; i++) begin
            bus(1'b1, LFBCS_CTRL_ADDR, 4'hF, 8'h83 | 8'(i << 2));
            period(1, p);
            `LFBCS_CHK("frame period", frameLen(i), p)
        end
        bus(1'b1, LFBCS_CTRL_ADDR, 4'hF, 8'h82);
        period(2, p);
        `LFBCS_CHK("phase period", (1 << LFBCS_HF_SLF2) / 4, p)
        $display("frames done");
        // software tries the faster boost rates in turn
        for (i = 1; i < 4; i++) begin
            bus(1'b1, LFBCS_CTRL_ADDR, 4'hF, 8'hC3 | 8'(i << 4));
            period(0, p);
            `LFBCS_CHK("boost period", boostLen(i), p)
        end
        $display("boost done");
        // dual clock with the stage source clear keeps the fast taps
        bus(1'b1, LFBCS_MODE_ADDR, 4'hF, 8'h01);
        `LFBCS_CHK("dual hf pin", 1'b0, lfSrc)
        // low-frequency source through the divider stage, then as system clock
        bus(1'b1, LFBCS_MODE_ADDR, 4'hF, 8'h03);
        bus(1'b0, LFBCS_MODE_ADDR, 4'hF, 8'h00);
        `LFBCS_CHK("mode", 3'h3, q[2:0])
        `LFBCS_CHK("lf pin", 1'b1, lfSrc)
        bus(1'b1, LFBCS_CTRL_ADDR, 4'hF, 8'hC1);
        bus(1'b0, LFBCS_STATUS_ADDR, 4'hF, 8'h00);
        `LFBCS_CHK("lf source", 1'b1, q[LFBCS_ST_LF_BIT])
        period(1, p);
        `LFBCS_CHK("lf frame", 4 << LFBCS_LF_SLF1, p)
        period(0, p);
        `LFBCS_CHK("lf boost", 4 << LFBCS_LF_VF0, p)
        // base and boost code 11 still run from the fast clock
        bus(1'b1, LFBCS_CTRL_ADDR, 4'hF, 8'hF3);
        period(0, p);
        `LFBCS_CHK("lf mode boost 11", boostLen(3), p)
        period(2, p);
        `LFBCS_CHK("lf mode phase 11", (1 << LFBCS_HF_SLF3) / 4, p)
        bus(1'b1, LFBCS_MODE_ADDR, 4'hF, 8'h04);
        bus(1'b1, LFBCS_CTRL_ADDR, 4'hF, 8'hC0);
        period(1, p);
        `LFBCS_CHK("lf frame", 4 << LFBCS_LF_SLF0, p)
        $display("lf done");
        end_sim();
    end
endmodule : lfbcs_clock_select_tb_top
